//--- ssa_pkg.sv
// shared constants for the command admission and status block
package ssa_pkg;

  // ---------------------------------------------------------------
  // status codes
  // ---------------------------------------------------------------
  localparam logic [7:0] ST_GOOD = 8'h00;
  localparam logic [7:0] ST_CHECK = 8'h02;
  localparam logic [7:0] ST_COND_MET = 8'h04;
  localparam logic [7:0] ST_BUSY = 8'h08;
  localparam logic [7:0] ST_INTERMED = 8'h10;
  localparam logic [7:0] ST_INTERMED_MET = 8'h14;
  localparam logic [7:0] ST_RESV_CONFLICT = 8'h18;
  localparam logic [7:0] ST_QUEUE_FULL = 8'h28;
  localparam logic [7:0] STATUS_FIELD_MASK = 8'h3E;

  // ---------------------------------------------------------------
  // sense keys and additional sense codes
  // ---------------------------------------------------------------
  localparam logic [3:0] SK_NONE = 4'h0;
  localparam logic [3:0] SK_NOT_READY = 4'h2;
  localparam logic [3:0] SK_ILLEGAL_REQ = 4'h5;
  localparam logic [3:0] SK_UNIT_ATTN = 4'h6;
  localparam logic [3:0] SK_ABORTED = 4'hB;
  localparam logic [7:0] ASC_NONE = 8'h00;
  localparam logic [7:0] ASC_LUN_UNSUPPORTED = 8'h25;
  localparam logic [7:0] ASC_INVALID_OPCODE = 8'h20;
  localparam logic [7:0] ASC_INVALID_CDB = 8'h24;
  localparam logic [7:0] ASC_NOT_READY = 8'h04;
  localparam logic [7:0] ASC_UNIT_ATTN = 8'h29;
  localparam logic [7:0] ASC_OVERLAP = 8'h4E;
  localparam logic [7:0] ASCQ_NONE = 8'h00;

  // ---------------------------------------------------------------
  // opcodes and misc values
  // ---------------------------------------------------------------
  localparam logic [7:0] OP_INQUIRY = 8'h12;
  localparam logic [7:0] OP_REQ_SENSE = 8'h03;
  localparam logic [7:0] OP_PREFETCH10 = 8'h34;
  localparam logic [7:0] OP_PREFETCH16 = 8'h90;
  localparam logic [7:0] INQ_UNKNOWN_TYPE = 8'h7F;
  localparam int MAX_SAS_INITIATORS = 64;
  localparam int INIT_ID_W = 16;
  localparam int LUN_W = 8;

  // ---------------------------------------------------------------
  // admission outcomes
  // ---------------------------------------------------------------
  typedef enum logic [2:0] {
    SSA_ADMIT_RUN = 3'b000,
    SSA_ADMIT_QUEUE = 3'b001,
    SSA_ADMIT_REJECT = 3'b010,
    SSA_ADMIT_LOCAL = 3'b011
  } ssa_admit_t;

endpackage : ssa_pkg

//--- ssa_init_table.sv
// table of distinct initiators seen since the last srst
`timescale 1ns/10ps
module ssa_init_table #(
  parameter int DEPTH = ssa_pkg::MAX_SAS_INITIATORS
) (
  input wire logic ref_clk,
  input wire logic srst,
  input wire logic lookupValid,
  input wire logic [ssa_pkg::INIT_ID_W-1:0] lookupId,
  output logic admitted
);

  typedef struct packed {
    logic [DEPTH-1:0] used;
    logic [DEPTH-1:0][ssa_pkg::INIT_ID_W-1:0] ids;
  } ssa_tab_t;

  ssa_tab_t st_q;
  ssa_tab_t st_d;
  logic [DEPTH-1:0] hit;
  logic [DEPTH-1:0] freeOne;

  // ---------------------------------------------------------------
  // match and first free slot
  // ---------------------------------------------------------------
  genvar g;
  generate
    for (g = 0; g < DEPTH; g++) begin : gMatch
      assign hit[g] = st_q.used[g] && (st_q.ids[g] == lookupId);
      if (g == 0) begin : gFirst
        assign freeOne[g] = !st_q.used[g];
      end else begin : gRest
        assign freeOne[g] = !st_q.used[g] && (&st_q.used[g-1:0]);
      end
    end
  endgenerate

  // RULE_23: first initiators admitted
  assign admitted = (|hit) || (|freeOne);

  always_comb begin
    st_d = st_q;
    if (lookupValid && !(|hit)) begin
      for (int i = 0; i < DEPTH; i++) begin
        if (freeOne[i]) begin
          st_d.used[i] = 1'b1;
          st_d.ids[i] = lookupId;
        end
      end
    end
  end

  always_ff @(posedge ref_clk) begin
    if (srst) begin
      st_q <= '0;
    end else begin
      st_q <= st_d;
    end
  end

endmodule : ssa_init_table

//--- ssa_admission.sv
// command admission, status byte and sense data of the target
`timescale 1ns/10ps
// Contract
// RULE_01: one status byte, reserved bits zero
// RULE_02: success reports 00h
// RULE_03: error reports 02h, sense set
// RULE_04: unlinked prefetch success reports 04h
// RULE_05: busy without disconnect reports 08h
// RULE_06: never produce 10h or 14h
// RULE_07: foreign reservation reports 18h
// RULE_08: tagged queue full reports 28h
// RULE_09: queue full carries no sense
// RULE_10: fixed blocking check priority order
// RULE_11: report only top condition, no bus error
// RULE_12: queued commands defer execution
// RULE_13: check condition builds sense on valid lun
// RULE_14: next command from initiator clears sense
// RULE_15: nonzero lun is invalid
// RULE_16: invalid lun inquiry gives 7Fh, good
// RULE_17: invalid lun request sense gives lun sense
// RULE_18: other invalid lun commands check condition
// RULE_19: invalid lun never disturbs running command
// RULE_20: no overlapped command checking
// RULE_21: initiator should request sense after check
// RULE_22: initiator retries busy later or disconnect
// RULE_23: busy beyond first 64 initiators
// RULE_24: inquiry runs despite pending unit attention
// RULE_25: standard sense key and asc values
module ssa_admission #(
  parameter int MAX_INIT = ssa_pkg::MAX_SAS_INITIATORS
) (
  input wire logic ref_clk,
  input wire logic srst,
  input wire logic cmdValid,
  input wire logic [ssa_pkg::INIT_ID_W-1:0] cmdInitId,
  input wire logic [ssa_pkg::LUN_W-1:0] cmdLun,
  input wire logic [7:0] cmdOpcode,
  input wire logic cmdLinked,
  input wire logic cmdDiscPriv,
  input wire logic busError,
  input wire logic incorrectConn,
  input wire logic unitAttnPending,
  input wire logic ioActive,
  input wire logic otherInitActive,
  input wire logic tagQueueEn,
  input wire logic queueFull,
  input wire logic deferredErr,
  input wire logic startupFormat,
  input wire logic reservedByOther,
  input wire logic opcodeInvalid,
  input wire logic cdbInvalid,
  input wire logic doneValid,
  input wire logic [ssa_pkg::INIT_ID_W-1:0] doneInitId,
  input wire logic doneError,
  input wire logic [3:0] doneSenseKey,
  input wire logic [7:0] doneAsc,
  input wire logic [7:0] doneAscq,
  output logic admitValid,
  output logic [2:0] admitAction,
  output logic statusValid,
  output logic [7:0] statusByte,
  output logic [ssa_pkg::INIT_ID_W-1:0] statusInitId,
  output logic inquiryUnknown,
  output logic [7:0] inquiryByte0,
  output logic senseValid,
  output logic [3:0] senseKey,
  output logic [7:0] senseAsc,
  output logic [7:0] senseAscq,
  output logic [ssa_pkg::INIT_ID_W-1:0] senseOwner
);

  typedef struct packed {
    logic admitValid;
    logic [2:0] admitAction;
    logic statusValid;
    logic [7:0] statusByte;
    logic [ssa_pkg::INIT_ID_W-1:0] statusInitId;
    logic inquiryUnknown;
    logic [7:0] inquiryByte0;
    logic senseValid;
    logic [3:0] senseKey;
    logic [7:0] senseAsc;
    logic [7:0] senseAscq;
    logic [ssa_pkg::INIT_ID_W-1:0] senseOwner;
    logic [7:0] prefetchOp;
  } ssa_state_t;

  ssa_state_t st_q;
  ssa_state_t st_d;
  logic initAdmitted;

  // ---------------------------------------------------------------
  // helpers
  // ---------------------------------------------------------------
  // RULE_01: keep status field, zero reserved bits
  function automatic logic [7:0] ssaStatus(input logic [7:0] code);
    ssaStatus = code & ssa_pkg::STATUS_FIELD_MASK;
  endfunction : ssaStatus

  function automatic logic ssaIsPrefetch(input logic [7:0] op);
    ssaIsPrefetch = (op == ssa_pkg::OP_PREFETCH10) ||
                    (op == ssa_pkg::OP_PREFETCH16);
  endfunction : ssaIsPrefetch

  // ---------------------------------------------------------------
  // initiator tracking
  // ---------------------------------------------------------------
  ssa_init_table #(
    .DEPTH(MAX_INIT)
  ) uInitTable (
    .ref_clk(ref_clk),
    .srst(srst),
    .lookupValid(cmdValid),
    .lookupId(cmdInitId),
    .admitted(initAdmitted)
  );

  // ---------------------------------------------------------------
  // admission and completion
  // ---------------------------------------------------------------
  always_comb begin
    logic lunBad;
    logic isInq;
    logic isRs;
    logic busyCond;
    logic qFullCond;
    logic setSense;
    logic [3:0] sk;
    logic [7:0] asc;
    logic [7:0] code;
    ssa_pkg::ssa_admit_t act;
    lunBad = 1'b0;
    isInq = 1'b0;
    isRs = 1'b0;
    busyCond = 1'b0;
    qFullCond = 1'b0;
    setSense = 1'b0;
    sk = ssa_pkg::SK_NONE;
    asc = ssa_pkg::ASC_NONE;
    code = ssa_pkg::ST_GOOD;
    act = ssa_pkg::SSA_ADMIT_RUN;
    st_d = st_q;
    st_d.admitValid = 1'b0;
    st_d.statusValid = 1'b0;
    st_d.inquiryUnknown = 1'b0;
    // RULE_15: only lun zero is valid
    lunBad = (cmdLun != '0);
    isInq = (cmdOpcode == ssa_pkg::OP_INQUIRY);
    isRs = (cmdOpcode == ssa_pkg::OP_REQ_SENSE);
    // RULE_05: busy without disconnect privilege
    busyCond = (otherInitActive && !cmdDiscPriv) || !initAdmitted;
    // RULE_08: tagged queue full
    qFullCond = tagQueueEn && ioActive && queueFull;
    if (cmdValid && !busError) begin
      // RULE_14: new command clears owner sense
      if (st_q.senseValid && st_q.senseOwner == cmdInitId && !isRs &&
          !lunBad) begin
        st_d.senseValid = 1'b0;
      end
      st_d.admitValid = 1'b1;
      st_d.statusInitId = cmdInitId;
      // RULE_10: fixed priority chain, RULE_11 one result
      if (lunBad) begin
        // RULE_19: local answer, no queue effect
        act = ssa_pkg::SSA_ADMIT_LOCAL;
        if (isInq) begin
          // RULE_16: unknown device type, good
          st_d.inquiryUnknown = 1'b1;
          st_d.inquiryByte0 = ssa_pkg::INQ_UNKNOWN_TYPE;
          code = ssa_pkg::ST_GOOD;
        end else if (isRs) begin
          // RULE_17: lun not supported sense, good
          code = ssa_pkg::ST_GOOD;
          sk = ssa_pkg::SK_ILLEGAL_REQ;
          asc = ssa_pkg::ASC_LUN_UNSUPPORTED;
          setSense = 1'b1;
        end else begin
          // RULE_18: check condition with autosense
          act = ssa_pkg::SSA_ADMIT_REJECT;
          code = ssa_pkg::ST_CHECK;
          sk = ssa_pkg::SK_ILLEGAL_REQ;
          asc = ssa_pkg::ASC_LUN_UNSUPPORTED;
          setSense = 1'b1;
        end
      // RULE_20: overlap never checked here
      end else if (incorrectConn) begin
        act = ssa_pkg::SSA_ADMIT_REJECT;
        code = ssa_pkg::ST_CHECK;
        sk = ssa_pkg::SK_ABORTED;
        asc = ssa_pkg::ASC_OVERLAP;
        setSense = 1'b1;
      // RULE_24: inquiry passes pending attention
      end else if (unitAttnPending && !isInq && !isRs) begin
        act = ssa_pkg::SSA_ADMIT_REJECT;
        code = ssa_pkg::ST_CHECK;
        sk = ssa_pkg::SK_UNIT_ATTN;
        asc = ssa_pkg::ASC_UNIT_ATTN;
        setSense = 1'b1;
      end else if (busyCond) begin
        // RULE_23: busy for initiators past table
        act = ssa_pkg::SSA_ADMIT_REJECT;
        code = ssa_pkg::ST_BUSY;
      end else if (qFullCond) begin
        // RULE_09: queue full builds no sense
        act = ssa_pkg::SSA_ADMIT_REJECT;
        code = ssa_pkg::ST_QUEUE_FULL;
      end else if (deferredErr) begin
        act = ssa_pkg::SSA_ADMIT_REJECT;
        code = ssa_pkg::ST_CHECK;
        sk = ssa_pkg::SK_ABORTED;
        setSense = 1'b1;
      end else if (startupFormat) begin
        act = ssa_pkg::SSA_ADMIT_REJECT;
        code = ssa_pkg::ST_CHECK;
        sk = ssa_pkg::SK_NOT_READY;
        asc = ssa_pkg::ASC_NOT_READY;
        setSense = 1'b1;
      end else if (reservedByOther) begin
        // RULE_07: reservation conflict
        act = ssa_pkg::SSA_ADMIT_REJECT;
        code = ssa_pkg::ST_RESV_CONFLICT;
      end else if (opcodeInvalid) begin
        act = ssa_pkg::SSA_ADMIT_REJECT;
        code = ssa_pkg::ST_CHECK;
        sk = ssa_pkg::SK_ILLEGAL_REQ;
        asc = ssa_pkg::ASC_INVALID_OPCODE;
        setSense = 1'b1;
      end else if (cdbInvalid) begin
        act = ssa_pkg::SSA_ADMIT_REJECT;
        code = ssa_pkg::ST_CHECK;
        sk = ssa_pkg::SK_ILLEGAL_REQ;
        asc = ssa_pkg::ASC_INVALID_CDB;
        setSense = 1'b1;
      end else if (ioActive) begin
        // RULE_12: defer into the command queue
        act = ssa_pkg::SSA_ADMIT_QUEUE;
      end else begin
        act = ssa_pkg::SSA_ADMIT_RUN;
      end
      st_d.admitAction = act;
      if (act != ssa_pkg::SSA_ADMIT_REJECT) begin
        st_d.prefetchOp = (ssaIsPrefetch(cmdOpcode) && !cmdLinked) ?
                          8'h01 : 8'h00;
      end else begin
        // RULE_06: only defined codes reach here
        st_d.statusValid = 1'b1;
        st_d.statusByte = ssaStatus(code);
      end
      if (setSense) begin
        // RULE_13: sense built, lun sense always known
        st_d.senseValid = 1'b1;
        st_d.senseKey = sk;
        st_d.senseAsc = asc;
        st_d.senseAscq = ssa_pkg::ASCQ_NONE;
        st_d.senseOwner = cmdInitId;
      end
    end else if (doneValid) begin
      st_d.statusValid = 1'b1;
      st_d.statusInitId = doneInitId;
      if (doneError) begin
        // RULE_03: check condition and sense
        st_d.statusByte = ssaStatus(ssa_pkg::ST_CHECK);
        st_d.senseValid = 1'b1;
        // RULE_25: sense fields as supplied
        st_d.senseKey = doneSenseKey;
        st_d.senseAsc = doneAsc;
        st_d.senseAscq = doneAscq;
        st_d.senseOwner = doneInitId;
      end else if (st_q.prefetchOp[0]) begin
        // RULE_04: unlinked prefetch condition met
        st_d.statusByte = ssaStatus(ssa_pkg::ST_COND_MET);
      end else begin
        // RULE_02: good completion
        st_d.statusByte = ssaStatus(ssa_pkg::ST_GOOD);
      end
    end
  end

  always_ff @(posedge ref_clk) begin
    if (srst) begin
      st_q <= '0;
    end else begin
      st_q <= st_d;
    end
  end

  // ---------------------------------------------------------------
  // outputs
  // ---------------------------------------------------------------
  assign admitValid = st_q.admitValid;
  assign admitAction = st_q.admitAction;
  assign statusValid = st_q.statusValid;
  assign statusByte = st_q.statusByte;
  assign statusInitId = st_q.statusInitId;
  assign inquiryUnknown = st_q.inquiryUnknown;
  assign inquiryByte0 = st_q.inquiryByte0;
  assign senseValid = st_q.senseValid;
  assign senseKey = st_q.senseKey;
  assign senseAsc = st_q.senseAsc;
  assign senseAscq = st_q.senseAscq;
  assign senseOwner = st_q.senseOwner;

  // ---------------------------------------------------------------
  // checks
  // ---------------------------------------------------------------
  rsvd_zero_a: assert property (@(posedge ref_clk) disable iff (srst) // RULE_01
    statusValid |-> (statusByte[7:6] == 2'b00 && statusByte[0] == 1'b0))
    else $error("status reserved bits set");
  no_intermed_a: assert property (@(posedge ref_clk) disable iff (srst) // RULE_06
    statusValid |-> (statusByte != ssa_pkg::ST_INTERMED &&
                     statusByte != ssa_pkg::ST_INTERMED_MET))
    else $error("intermediate status produced");
  bad_lun_a: assert property (@(posedge ref_clk) disable iff (srst) // RULE_18
    (cmdValid && !busError && cmdLun != '0 &&
     cmdOpcode != ssa_pkg::OP_INQUIRY && cmdOpcode != ssa_pkg::OP_REQ_SENSE)
    |=> (statusByte == ssa_pkg::ST_CHECK && senseValid &&
         senseAsc == ssa_pkg::ASC_LUN_UNSUPPORTED))
    else $error("invalid lun not rejected");
  inq_lun_a: assert property (@(posedge ref_clk) disable iff (srst) // RULE_16
    (cmdValid && !busError && cmdLun != '0 &&
     cmdOpcode == ssa_pkg::OP_INQUIRY)
    |=> (inquiryUnknown && inquiryByte0 == ssa_pkg::INQ_UNKNOWN_TYPE &&
         !statusValid))
    else $error("inquiry on invalid lun wrong");
  logic busyCond_h;
  assign busyCond_h = (otherInitActive && !cmdDiscPriv) || !initAdmitted;
  qfull_a: assert property (@(posedge ref_clk) disable iff (srst) // RULE_08
    (cmdValid && !busError && cmdLun == '0 && !incorrectConn &&
     !unitAttnPending && !busyCond_h && tagQueueEn && ioActive && queueFull)
    |=> (statusValid && statusByte == ssa_pkg::ST_QUEUE_FULL))
    else $error("queue full not reported");
  resv_a: assert property (@(posedge ref_clk) disable iff (srst) // RULE_07
    (statusValid && statusByte == ssa_pkg::ST_RESV_CONFLICT)
    |-> $past(reservedByOther))
    else $error("conflict without reservation");
  bus_err_a: assert property (@(posedge ref_clk) disable iff (srst) // RULE_11
    (busError && !doneValid) |=> !admitValid && !statusValid)
    else $error("answer during bus error");
  sense_clr_a: assert property (@(posedge ref_clk) disable iff (srst) // RULE_14
    (senseValid && cmdValid && !busError && cmdInitId == senseOwner &&
     cmdLun == '0 && cmdOpcode != ssa_pkg::OP_REQ_SENSE && !incorrectConn &&
     !unitAttnPending && !deferredErr && !startupFormat &&
     !opcodeInvalid && !cdbInvalid)
    |=> !senseValid)
    else $error("sense not cleared");

endmodule : ssa_admission

//--- ssa_host_model.sv
// initiator host model issuing commands and completions
`timescale 1ns/10ps
module ssa_host_model (
  input wire logic ref_clk,
  output logic cmdValid,
  output logic [ssa_pkg::INIT_ID_W-1:0] cmdInitId,
  output logic [ssa_pkg::LUN_W-1:0] cmdLun,
  output logic [7:0] cmdOpcode,
  output logic cmdLinked,
  output logic cmdDiscPriv,
  output logic doneValid,
  output logic [ssa_pkg::INIT_ID_W-1:0] doneInitId,
  output logic doneError,
  output logic [3:0] doneSenseKey,
  output logic [7:0] doneAsc,
  output logic [7:0] doneAscq
);
  integer seed = 41;
  initial begin
    {cmdValid, cmdInitId, cmdLun, cmdOpcode, cmdLinked, cmdDiscPriv} = '0;
    {doneValid, doneInitId, doneError, doneSenseKey, doneAsc, doneAscq} = '0;
  end
  // ---------------------------------------------------------------
  // requests, each held for one edge
  // ---------------------------------------------------------------
  task automatic send(input logic [15:0] id, input logic [7:0] lun,
      input logic [7:0] op, input logic lnk, input logic dp);
    {cmdValid, cmdInitId, cmdLun, cmdOpcode} <= {1'b1, id, lun, op};
    {cmdLinked, cmdDiscPriv} <= {lnk, dp};
    doneValid <= 1'b0;
    @(posedge ref_clk);
  endtask : send
  task automatic finish(input logic [15:0] id, input logic err,
      input logic [3:0] key, input logic [7:0] asc);
    cmdValid <= 1'b0;
    {doneValid, doneInitId, doneError} <= {1'b1, id, err};
    {doneSenseKey, doneAsc, doneAscq} <= {key, asc, 8'($random(seed))};
    @(posedge ref_clk);
  endtask : finish
  // released ids, lun, opcode, key and asc scrambled; ascq kept
  task automatic idle();
    cmdValid <= 1'b0;
    doneValid <= 1'b0;
    {cmdInitId, cmdLun, cmdOpcode} <= 32'($random(seed));
    {doneInitId, doneSenseKey, doneAsc} <= 28'($random(seed));
    @(posedge ref_clk);
  endtask : idle
endmodule : ssa_host_model

//--- tb_ssa_admission.sv
// self-checking bench for the command admission block
`timescale 1ns/10ps
module tb_ssa_admission;
  logic ref_clk = 1'b0;
  logic srst = 1'b1;
  logic busError = 1'b0;
  logic [10:0] cond = '0;
  logic cmdValid, cmdLinked, cmdDiscPriv, doneValid, doneError;
  logic [15:0] cmdInitId, doneInitId, statusInitId, senseOwner;
  logic [7:0] cmdLun, cmdOpcode, doneAsc, doneAscq, statusByte;
  logic [7:0] inquiryByte0, senseAsc, senseAscq;
  logic [3:0] doneSenseKey, senseKey;
  logic [2:0] admitAction;
  logic admitValid, statusValid, inquiryUnknown, senseValid;
  logic [3:0] aQ[$];
  logic [23:0] sQ[$];
  int err_count = 0;
  int checked = 0;
  logic [7:0] pSb [9] = '{8'h02, 8'h02, 8'h02, 8'h08, 8'h02, 8'h02,
    8'h18, 8'h02, 8'h02};
  logic [11:0] pSk [9] = '{12'h525, 12'hB4E, 12'h629, 12'h000, 12'hFFF,
    12'h204, 12'h000, 12'h520, 12'h524};

  ssa_admission #(.MAX_INIT(4)) i_dut (.ref_clk(ref_clk), .srst(srst),
    .cmdValid(cmdValid), .cmdInitId(cmdInitId), .cmdLun(cmdLun),
    .cmdOpcode(cmdOpcode), .cmdLinked(cmdLinked), .cmdDiscPriv(cmdDiscPriv),
    .busError(busError), .incorrectConn(cond[0]),
    .unitAttnPending(cond[1]), .otherInitActive(cond[2]),
    .deferredErr(cond[3]), .startupFormat(cond[4]),
    .reservedByOther(cond[5]), .opcodeInvalid(cond[6]),
    .cdbInvalid(cond[7]), .ioActive(cond[8]), .tagQueueEn(cond[9]),
    .queueFull(cond[10]), .doneValid(doneValid), .doneInitId(doneInitId),
    .doneError(doneError), .doneSenseKey(doneSenseKey), .doneAsc(doneAsc),
    .doneAscq(doneAscq), .admitValid(admitValid), .admitAction(admitAction),
    .statusValid(statusValid), .statusByte(statusByte),
    .statusInitId(statusInitId), .inquiryUnknown(inquiryUnknown),
    .inquiryByte0(inquiryByte0), .senseValid(senseValid),
    .senseKey(senseKey), .senseAsc(senseAsc), .senseAscq(senseAscq),
    .senseOwner(senseOwner));

  ssa_host_model i_host (.ref_clk(ref_clk), .cmdValid(cmdValid),
    .cmdInitId(cmdInitId), .cmdLun(cmdLun), .cmdOpcode(cmdOpcode),
    .cmdLinked(cmdLinked), .cmdDiscPriv(cmdDiscPriv),
    .doneValid(doneValid), .doneInitId(doneInitId), .doneError(doneError),
    .doneSenseKey(doneSenseKey), .doneAsc(doneAsc), .doneAscq(doneAscq));

  initial forever #20 ref_clk = ~ref_clk;

  // ---------------------------------------------------------------
  // drivers and compares
  // ---------------------------------------------------------------
  task automatic fail(input string m);
    $display("unexpected at %0t: %s", $time, m);
    err_count++;
  endtask : fail
  task automatic cmd(input logic [15:0] id, input logic [7:0] lun,
      input logic [7:0] op, input logic [10:0] c, input logic [2:0] act,
      input logic [7:0] sb, input logic lnk = 1'b0, input logic dp = 1'b0);
    cond <= c;
    if (act != 3'h7) aQ.push_back({act, act == 3'h3 && op == 8'h12});
    if (act == 3'h2) sQ.push_back({id, sb});
    i_host.send(id, lun, op, lnk, dp);
  endtask : cmd
  task automatic done(input logic [15:0] id, input logic err,
      input logic [7:0] sb);
    sQ.push_back({id, sb});
    i_host.finish(id, err, 4'h3, 8'h11);
    i_host.idle();
  endtask : done
  task automatic chk_adm();
    logic [3:0] e;
    checked++;
    if (aQ.size() == 0) fail("admit with no command");
    else begin
      e = aQ.pop_front();
      if ({admitAction, inquiryUnknown} !== e) fail("admit action");
      if (e[0] && inquiryByte0 !== 8'h7F) fail("inquiry byte 0");
    end
  endtask : chk_adm
  task automatic chk_st();
    logic [23:0] e;
    checked++;
    if (sQ.size() == 0) fail("status with no cause");
    else begin
      e = sQ.pop_front();
      if ({statusInitId, statusByte} !== e) fail("status byte");
    end
    if ((statusByte & ~ssa_pkg::STATUS_FIELD_MASK) !== 8'h00 ||
        statusByte === 8'h10 || statusByte === 8'h14) fail("status code");
  endtask : chk_st
  task automatic chk_sense(input logic v, input logic [11:0] ka,
      input logic [15:0] o, input logic [7:0] q = 8'h00);
    i_host.idle();
    @(negedge ref_clk);
    checked++;
    if (senseValid !== v || (v && ka != 12'hFFF &&
        ({senseKey, senseAsc, senseAscq} !== {ka, q} || senseOwner !== o)))
      fail("sense data");
    @(posedge ref_clk);
  endtask : chk_sense
  task automatic end_sim();
    $display("checked %0d mismatches %0d", checked, err_count);
    if (err_count == 0 && checked > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask : end_sim
  task automatic fin(input string name);
    i_host.idle();
    for (int k = 0; k < 20 && aQ.size() + sQ.size() > 0; k++)
      @(posedge ref_clk);
    if (aQ.size() + sQ.size() > 0) begin
      fail("answer missing");
      end_sim();
    end
    $display("test %s done", name);
  endtask : fin

  always @(negedge ref_clk) begin
    if (admitValid === 1'b1) chk_adm();
    if (statusValid === 1'b1) chk_st();
  end

  // ---------------------------------------------------------------
  // scenarios
  // ---------------------------------------------------------------
  initial begin
    repeat (4) @(posedge ref_clk);
    srst <= 1'b0;
    @(posedge ref_clk);
    chk_sense(1'b0, 12'h000, 16'h0000);
    for (int i = 1; i <= 4; i++)
      cmd(16'(i), 8'h00, 8'h28, '0, 3'h0, 8'h00);
    cmd(16'h0009, 8'h00, 8'h28, '0, 3'h2, 8'h08);
    cmd(16'h0001, 8'h00, 8'h28, '0, 3'h0, 8'h00);
    fin("initiator table");
    cmd(16'h0001, 8'h00, 8'h28, '0, 3'h0, 8'h00);
    cmd(16'h0002, 8'h05, 8'h2A, '0, 3'h2, 8'h02);
    chk_sense(1'b1, 12'h525, 16'h0002);
    done(16'h0001, 1'b0, 8'h00);
    cmd(16'h0002, 8'h00, 8'h03, '0, 3'h0, 8'h00);
    chk_sense(1'b1, 12'h525, 16'h0002);
    cmd(16'h0002, 8'h00, 8'h28, '0, 3'h0, 8'h00);
    chk_sense(1'b0, 12'h000, 16'h0002);
    done(16'h0002, 1'b1, 8'h02);
    chk_sense(1'b1, 12'h311, 16'h0002, doneAscq);
    fin("run and invalid unit");
    for (int j = 0; j < 3; j++) begin
      cmd(16'h0003, 8'h00, j == 1 ? 8'h90 : 8'h34, '0, 3'h0, 8'h00, j == 2);
      done(16'h0003, 1'b0, j == 2 ? 8'h00 : 8'h04);
    end
    fin("prefetch");
    cmd(16'h0003, 8'h01, 8'h12, 11'h002, 3'h3, 8'h00);
    done(16'h0003, 1'b0, 8'h00);
    cmd(16'h0004, 8'h02, 8'h03, '0, 3'h3, 8'h00);
    chk_sense(1'b1, 12'h525, 16'h0004);
    done(16'h0004, 1'b0, 8'h00);
    fin("local invalid unit");
    for (int i = 0; i < 9; i++) begin
      cmd(16'h0004, i == 0 ? 8'h01 : 8'h00, 8'h00,
        {3'b000, 8'hFF << (i == 0 ? 0 : i - 1)}, 3'h2, pSb[i]);
      chk_sense(pSk[i] != 12'h000, pSk[i], 16'h0004);
    end
    cmd(16'h0004, 8'h00, 8'h28, 11'h708, 3'h2, 8'h28);
    chk_sense(1'b0, 12'h000, 16'h0004);
    cmd(16'h0004, 8'h00, 8'h28, 11'h100, 3'h1, 8'h00);
    cmd(16'h0001, 8'h00, 8'h28, 11'h004, 3'h2, 8'h08);
    cmd(16'h0001, 8'h00, 8'h28, 11'h004, 3'h0, 8'h00, 1'b0, 1'b1);
    cmd(16'h0002, 8'h00, 8'h12, 11'h002, 3'h0, 8'h00);
    busError <= 1'b1;
    cmd(16'h0002, 8'h00, 8'h28, 11'h0FF, 3'h7, 8'h00);
    busError <= 1'b0;
    fin("blocking conditions");
    end_sim();
  end
endmodule : tb_ssa_admission
